/* File: hw/ssp_pkg.sv */
package ssp_pkg;
  // register byte offsets
  localparam logic [4:0] SSP_OFS_CTRL = 5'h00;
  localparam logic [4:0] SSP_OFS_STAT = 5'h04;
  localparam logic [4:0] SSP_OFS_BUF  = 5'h08;
  localparam logic [4:0] SSP_OFS_DIR  = 5'h0c;
  localparam logic [4:0] SSP_OFS_EVT  = 5'h10;
  // serial_port_control_one fields
  localparam int SSP_CTL_WRITE_COLLISION_FLAG = 7;
  localparam int SSP_CTL_OVF  = 6;
  localparam int SSP_CTL_EN   = 5;
  localparam int SSP_CTL_POL  = 4;
  // serial_port_status_reg fields
  localparam int SSP_STA_PHASE = 7;
  localparam int SSP_STA_EDGE  = 6;
  localparam int SSP_STA_FULL  = 0;
  // pin_direction_bits fields, 1 = input
  localparam int SSP_DIR_SDO = 0;
  localparam int SSP_DIR_SCK = 1;
  localparam int SSP_DIR_SS  = 2;
  // event register field
  localparam int SSP_EVT_INT = 0;
  // reset values
  localparam logic [7:0] SSP_CTRL_RST = 8'h00;
  localparam logic [7:0] SSP_STAT_RST = 8'h00;
  localparam logic [7:0] SSP_DIR_RST  = 8'h07;
  // mode select codes
  localparam logic [3:0] SSP_MODE_DIV4   = 4'h0;
  localparam logic [3:0] SSP_MODE_DIV16  = 4'h1;
  localparam logic [3:0] SSP_MODE_DIV64  = 4'h2;
  localparam logic [3:0] SSP_MODE_TIMER_TWO   = 4'h3;
  localparam logic [3:0] SSP_MODE_SLV_SS = 4'h4;
  localparam logic [3:0] SSP_MODE_SLV    = 4'h5;
  // system clock divisors per bit; half a bit per serial clock edge
  localparam int SSP_DIV_4  = 4;
  localparam int SSP_DIV_16 = 16;
  localparam int SSP_DIV_64 = 64;
  localparam int SSP_BITS   = 8;
  localparam logic [4:0] SSP_LAST_EDGE = 5'h0f;
  typedef enum logic [1:0] {
    SSP_ST_IDLE  = 2'b00,
    SSP_ST_SHIFT = 2'b01,
    SSP_ST_END   = 2'b11
  } ssp_state_t;
endpackage : ssp_pkg

/* File: hw/ssp_rate_gen.sv */
`timescale 1ns/10ps
module ssp_rate_gen
  import ssp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       run,
  input  wire logic [3:0] rateSel,
  input  wire logic       timerTwoTick,
  output logic            halfTick
);
  logic [4:0] count_reg;
  logic [4:0] count_next;
  logic [4:0] limit;

  always_comb begin
    if (rateSel == SSP_MODE_DIV16) begin
      limit = 5'((SSP_DIV_16 / 2) - 1);
    end else if (rateSel == SSP_MODE_DIV64) begin
      limit = 5'((SSP_DIV_64 / 2) - 1);
    end else begin
      limit = 5'((SSP_DIV_4 / 2) - 1);
    end
  end

  always_comb begin
    count_next = 5'h00;
    halfTick   = 1'b0;
    if (run) begin
      if (rateSel == SSP_MODE_TIMER_TWO) begin
        // two timer pulses per bit: one per clock half
        halfTick = timerTwoTick;
      end else if (count_reg == limit) begin
        halfTick = 1'b1;
      end else begin
        count_next = count_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 5'h00;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : ssp_rate_gen

/* File: hw/ssp_spi_port.sv */
// Operation
// - a buffer write during a byte is ignored and sets write collision
// - setting the enable bit turns the serial port on
// - when enabled the port owns data in, data out, clock, slave select
// - clock idles high with polarity one, low with polarity zero
// - codes 0011, 0010, 0001, 0000 pick master clock source; master drives clock
// - codes 0101 and 0100 pick slave; 0100 uses slave select, 0101 not
// - sample phase picks middle or end of output time for input sampling
// - clock edge setting picks rising or falling edge for output changes
// - shift register moves data most significant bit first
// - after eight bits, byte goes to buffer, full and event flags set
// - receive is double buffered so next byte may start before read
// - reading the transfer buffer clears the buffer full flag
// - shift register only reachable through the transfer buffer address
// - port always keeps the serial data input pin as input
// - a direction bit set opposite overrides that pin's serial function; the clock bit is ignored in slave mode
// - master buffer write starts a byte at once; ignored while the write collision flag is set
// - edge setting one shifts out on active-to-idle, zero on idle-to-active
// - slave with select control stops driving data out once select high
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
module ssp_spi_port
  import ssp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [4:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic [31:0]      avsReadData,
  output logic             avsWaitRequest,
  input  wire logic        timerTwoTick,
  input  wire logic        sckIn,
  output logic             sckOut,
  output logic             sckOe,
  output logic             sdoOut,
  output logic             sdoOe,
  input  wire logic        sdiIn,
  input  wire logic        ssInN
);
  // register group
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [7:0]  stat_reg, stat_next;
  logic [7:0]  dir_reg, dir_next;
  logic [7:0]  buf_reg, buf_next;
  logic        intFlag_reg, intFlag_next;
  logic        rdAck_reg, rdAck_next;
  logic [31:0] readData_reg, readData_next;
  // shift engine group
  ssp_state_t  state_reg, state_next;
  logic [7:0]  shift_reg, shift_next;
  logic [4:0]  edgeIdx_reg, edgeIdx_next;
  logic [3:0]  bitCnt_reg, bitCnt_next;
  logic        sdoBit_reg, sdoBit_next;
  logic        active_reg, active_next;
  logic        sckPrev_reg, sckPrev_next;

  logic        portEn, isMaster, isSlave, ssCtl, ssActive;
  logic        clkPol, cke, input_sample_phase;
  logic [3:0]  mode;
  logic        busy, halfTick, ev, isLead, isTrail, isEnd;
  logic        pinEdge, pinLead, outEdge, midEdge, sampleEv;
  logic        rxDone;
  logic [7:0]  rxByte;
  logic        wrLane, bufWrite, bufRead, loadReq, collide;

  assign portEn = ctrl_reg[SSP_CTL_EN];
  assign clkPol = ctrl_reg[SSP_CTL_POL];
  assign mode   = ctrl_reg[3:0];
  assign cke    = stat_reg[SSP_STA_EDGE];
  assign input_sample_phase    = stat_reg[SSP_STA_PHASE];
  // unlisted codes leave the port inert
  assign isMaster = portEn && (mode <= SSP_MODE_TIMER_TWO);
  assign isSlave  = portEn && (mode == SSP_MODE_SLV_SS || mode == SSP_MODE_SLV);
  // select pin turned to output by software drops the select function
  assign ssCtl    = isSlave && (mode == SSP_MODE_SLV_SS) && dir_reg[SSP_DIR_SS];
  assign ssActive = !ssCtl || !ssInN;
  assign busy     = isMaster ? (state_reg != SSP_ST_IDLE) : (edgeIdx_reg != 5'h00);

  ssp_rate_gen u_rate (
    .sys_clk      (sys_clk),
    .reset_n      (reset_n),
    .run          (isMaster && state_reg != SSP_ST_IDLE),
    .rateSel      (mode),
    .timerTwoTick (timerTwoTick),
    .halfTick     (halfTick)
  );

  // bus decode
  assign wrLane   = avsWrite && avsByteEnable[0];
  assign bufWrite = wrLane && avsAddress == SSP_OFS_BUF;
  assign bufRead  = avsRead && rdAck_reg && avsAddress == SSP_OFS_BUF;
  // buffer writes ignored, not stalled, until software clears the collision flag
  assign collide  = bufWrite && portEn && busy;
  assign loadReq  = bufWrite && portEn && !busy && !ctrl_reg[SSP_CTL_WRITE_COLLISION_FLAG];
  // reads wait one cycle so data stands when waitrequest drops
  assign avsWaitRequest = avsRead && !rdAck_reg;
  assign avsReadData    = readData_reg;

  // pins; data input never driven, no enable exists for it
  assign sckOut = clkPol ^ active_reg;
  assign sckOe  = isMaster && !dir_reg[SSP_DIR_SCK];
  assign sdoOut = sdoBit_reg;
  // select high cuts the driver at once, even mid byte
  assign sdoOe  = (isMaster || isSlave) && !dir_reg[SSP_DIR_SDO] && ssActive;

  // shift engine
  always_comb begin
    state_next   = state_reg;
    shift_next   = shift_reg;
    edgeIdx_next = edgeIdx_reg;
    bitCnt_next  = bitCnt_reg;
    sdoBit_next  = sdoBit_reg;
    active_next  = active_reg;
    sckPrev_next = sckIn;
    rxDone       = 1'b0;
    rxByte       = {shift_reg[6:0], sdiIn};
    // slave edges: pin is synchronous, compare with last sample
    pinEdge = isSlave && ssActive && (sckIn != sckPrev_reg);
    pinLead = pinEdge && (sckIn != clkPol);
    ev      = isMaster ? (halfTick && state_reg != SSP_ST_IDLE) : pinEdge;
    isLead  = isMaster ? (state_reg == SSP_ST_SHIFT && !edgeIdx_reg[0]) : pinLead;
    isTrail = isMaster ? (state_reg == SSP_ST_SHIFT && edgeIdx_reg[0])
                       : (pinEdge && !pinLead);
    isEnd   = isMaster && state_reg == SSP_ST_END;
    // the end tick closes the last bit time when output moves on leading edges
    outEdge  = ev && (cke ? isTrail : (isLead || isEnd));
    midEdge  = ev && (cke ? isLead : isTrail);
    sampleEv = input_sample_phase ? (outEdge && !(!cke && edgeIdx_reg == 5'h00)) : midEdge;
    if (outEdge) begin
      sdoBit_next = sampleEv ? shift_reg[6] : shift_reg[7];
    end
    if (sampleEv) begin
      shift_next  = {shift_reg[6:0], sdiIn};
      bitCnt_next = bitCnt_reg + 4'h1;
      if (bitCnt_reg == 4'(SSP_BITS - 1)) begin
        rxDone      = 1'b1;
        bitCnt_next = 4'h0;
      end
    end
    if (ev) begin
      edgeIdx_next = edgeIdx_reg + 5'h01;
    end
    if (isMaster) begin
      case (state_reg)
        SSP_ST_SHIFT: begin
          if (ev) begin
            active_next = !active_reg;
            if (edgeIdx_reg == SSP_LAST_EDGE) begin
              state_next = SSP_ST_END;
            end
          end
        end
        SSP_ST_END: begin
          if (ev) begin
            state_next   = SSP_ST_IDLE;
            edgeIdx_next = 5'h00;
            bitCnt_next  = 4'h0;
          end
        end
        default: begin
          state_next  = SSP_ST_IDLE;
          active_next = 1'b0;
        end
      endcase
    end else begin
      state_next  = SSP_ST_IDLE;
      active_next = 1'b0;
      // slave byte boundary, or select released, or port off: counter to zero
      if (!isSlave || !ssActive || rxDone) begin
        edgeIdx_next = 5'h00;
        bitCnt_next  = 4'h0;
      end
    end
    if (loadReq) begin
      shift_next   = avsWriteData[7:0];
      sdoBit_next  = avsWriteData[7];
      edgeIdx_next = 5'h00;
      bitCnt_next  = 4'h0;
      if (isMaster) begin
        state_next = SSP_ST_SHIFT;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= SSP_ST_IDLE;
      shift_reg   <= 8'h00;
      edgeIdx_reg <= 5'h00;
      bitCnt_reg  <= 4'h0;
      sdoBit_reg  <= 1'b0;
      active_reg  <= 1'b0;
      sckPrev_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      shift_reg   <= shift_next;
      edgeIdx_reg <= edgeIdx_next;
      bitCnt_reg  <= bitCnt_next;
      sdoBit_reg  <= sdoBit_next;
      active_reg  <= active_next;
      sckPrev_reg <= sckPrev_next;
    end
  end

  // registers and bus
  always_comb begin
    ctrl_next     = ctrl_reg;
    stat_next     = stat_reg;
    dir_next      = dir_reg;
    buf_next      = buf_reg;
    intFlag_next  = intFlag_reg;
    readData_next = readData_reg;
    rdAck_next    = avsRead && !rdAck_reg;
    if (avsRead && !rdAck_reg) begin
      if (avsAddress == SSP_OFS_CTRL) begin
        readData_next = {24'h000000, ctrl_reg};
      end else if (avsAddress == SSP_OFS_STAT) begin
        readData_next = {24'h000000, stat_reg};
      end else if (avsAddress == SSP_OFS_BUF) begin
        readData_next = {24'h000000, buf_reg};
      end else if (avsAddress == SSP_OFS_DIR) begin
        readData_next = {24'h000000, dir_reg};
      end else if (avsAddress == SSP_OFS_EVT) begin
        readData_next = {31'h00000000, intFlag_reg};
      end else begin
        readData_next = 32'h00000000;
      end
    end
    if (wrLane) begin
      if (avsAddress == SSP_OFS_CTRL) begin
        ctrl_next = avsWriteData[7:0];
      end else if (avsAddress == SSP_OFS_STAT) begin
        stat_next[SSP_STA_PHASE] = avsWriteData[SSP_STA_PHASE];
        stat_next[SSP_STA_EDGE]  = avsWriteData[SSP_STA_EDGE];
      end else if (avsAddress == SSP_OFS_DIR) begin
        dir_next = {5'h00, avsWriteData[2:0]};
      end else if (avsAddress == SSP_OFS_EVT) begin
        if (avsWriteData[SSP_EVT_INT]) begin
          intFlag_next = 1'b0;
        end
      end
    end
    if (loadReq) begin
      buf_next = avsWriteData[7:0];
    end
    if (bufRead) begin
      stat_next[SSP_STA_FULL] = 1'b0;
    end
    // hardware sets below win over software clears above
    if (collide) begin
      ctrl_next[SSP_CTL_WRITE_COLLISION_FLAG] = 1'b1;
    end
    if (rxDone) begin
      // a read in this same cycle empties the buffer first
      if (isSlave && stat_reg[SSP_STA_FULL] && !bufRead) begin
        ctrl_next[SSP_CTL_OVF] = 1'b1;
      end else begin
        buf_next                = rxByte;
        stat_next[SSP_STA_FULL] = 1'b1;
        intFlag_next            = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg     <= SSP_CTRL_RST;
      stat_reg     <= SSP_STAT_RST;
      dir_reg      <= SSP_DIR_RST;
      buf_reg      <= 8'h00;
      intFlag_reg  <= 1'b0;
      rdAck_reg    <= 1'b0;
      readData_reg <= 32'h00000000;
    end else begin
      ctrl_reg     <= ctrl_next;
      stat_reg     <= stat_next;
      dir_reg      <= dir_next;
      buf_reg      <= buf_next;
      intFlag_reg  <= intFlag_next;
      rdAck_reg    <= rdAck_next;
      readData_reg <= readData_next;
    end
  end
endmodule : ssp_spi_port

/* File: tb/spi_master_slave_port_test.sv */
`timescale 1ns/10ps
module spi_master_slave_port_test
  import ssp_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic        tick = 1'b0;
  logic        ssInN = 1'b1;
  logic        pol = 1'b0;
  logic        ld = 1'b0;
  logic        sdoLast = 1'b0;
  logic        sckPin = 1'b0;
  logic [1:0]  tc = 2'h0;
  logic [4:0]  avsAddress = 5'h00;
  logic [31:0] avsWriteData = 32'h0;
  logic [3:0]  avsByteEnable = 4'h1;
  logic [31:0] avsReadData;
  logic        avsWaitRequest, sckOut, sckOe, sdoOut, sdoOe, sdi;
  logic [7:0]  txB = 8'h00;
  logic [7:0]  rxB, rd8, b;
  logic [7:0]  sentQ[$], recvQ[$];
  integer      error_cnt = 0, check_count = 0, seed = 32'h9110, m, p;
  logic [4:0]  rstA[6] = '{SSP_OFS_CTRL, SSP_OFS_STAT, SSP_OFS_DIR, SSP_OFS_EVT, SSP_OFS_BUF,
                          5'h14};
  logic [7:0]  rstV[6] = '{SSP_CTRL_RST, SSP_STAT_RST, SSP_DIR_RST, 8'h00, 8'h00, 8'h00};
  // a released data line shows the inverse of its last driven level
  wire         sdoW = sdoOe ? sdoOut : ~sdoLast;
  wire         sckW = sckOe ? sckOut : sckPin;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tc <= tc + 2'h1;
    tick <= (tc == 2'h0);
    if (sdoOe) sdoLast <= sdoOut;
  end
  ssp_spi_port u_dut (.sys_clk, .reset_n, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsByteEnable, .avsReadData, .avsWaitRequest, .timerTwoTick(tick), .sckIn(sckPin),
    .sckOut, .sckOe, .sdoOut, .sdoOe, .sdiIn(sdi), .ssInN);
  ssp_spi_partner u_far (.sys_clk, .pol, .load(ld), .txByte(txB), .sck(sckW), .sdo(sdoW),
    .sdi, .rxByte(rxB));
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic lim(input logic hit);
    if (hit) begin
      error_cnt++;
      $display("FAIL wait expected answer seen none");
      give_verdict();
    end
  endtask : lim
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int k;
    @(posedge sys_clk);
    avsAddress <= a;
    avsWriteData <= {24'h0, d};
    avsWrite <= w;
    avsRead <= !w;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avsWaitRequest !== 1'b0 && k < 20);
    lim(k == 20);
    q = avsReadData[7:0];
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask : rd
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (rstA[i]) begin
      rd(rstA[i], rd8);
      chk("reset value", rstV[i], rd8);
    end
    wr(SSP_OFS_DIR, 8'h04);
    wr(SSP_OFS_STAT, 8'h40);
    // every master rate, both polarities
    for (m = 0; m < 8; m++) begin
      pol <= m[2];
      wr(SSP_OFS_CTRL, 8'h00);
      wr(SSP_OFS_CTRL, {3'b001, m[2], 2'b00, m[1:0]});
      repeat (2) @(posedge sys_clk);
      chk("sck idle", m[2], sckOut);
      chk("sck driven", 1'b1, sckOe);
      b = 8'($random(seed));
      txB <= b;
      recvQ.push_back(b);
      ld <= 1'b1;
      @(posedge sys_clk);
      ld <= 1'b0;
      b = 8'($random(seed));
      sentQ.push_back(b);
      wr(SSP_OFS_BUF, b);
      wr(SSP_OFS_BUF, ~b);
      rd(SSP_OFS_CTRL, rd8);
      chk("collision", 1'b1, rd8[SSP_CTL_WRITE_COLLISION_FLAG]);
      p = 0;
      do begin
        rd(SSP_OFS_STAT, rd8);
        p++;
      end while (rd8[SSP_STA_FULL] !== 1'b1 && p < 400);
      lim(p == 400);
      rd(SSP_OFS_EVT, rd8);
      chk("event", 1'b1, rd8[SSP_EVT_INT]);
      rd(SSP_OFS_BUF, rd8);
      chk("rx byte", recvQ.pop_front(), rd8);
      chk("tx byte", sentQ.pop_front(), rxB);
      rd(SSP_OFS_STAT, rd8);
      chk("full clear", 1'b0, rd8[SSP_STA_FULL]);
      wr(SSP_OFS_EVT, 8'h01);
    end
    repeat (620) @(posedge sys_clk);
    chk("sck rest", 1'b1, sckOut);
    // a write without lane 0 enabled must leave the register alone
    avsByteEnable <= 4'h0;
    wr(SSP_OFS_DIR, 8'h07);
    avsByteEnable <= 4'h1;
    rd(SSP_OFS_DIR, rd8);
    chk("lane off", 8'h04, rd8);
    // slave: select control decides whether data out is driven
    wr(SSP_OFS_DIR, 8'h06);
    for (m = 0; m < 4; m++) begin
      wr(SSP_OFS_CTRL, 8'h00);
      wr(SSP_OFS_CTRL, m[1] ? 8'h25 : 8'h24);
      ssInN <= m[0];
      repeat (3) @(posedge sys_clk);
      chk("sdo driven", !(m == 1), sdoOe);
      chk("sck slave", 1'b0, sckOe);
    end
    // slave bytes clocked from the bench; the second lands on a full buffer
    wr(SSP_OFS_CTRL, 8'h00);
    wr(SSP_OFS_CTRL, 8'h24);
    ssInN <= 1'b0;
    pol <= 1'b0;
    for (p = 0; p < 2; p++) begin
      b = 8'($random(seed));
      txB <= b;
      if (p == 0) recvQ.push_back(b);
      ld <= 1'b1;
      @(posedge sys_clk);
      ld <= 1'b0;
      b = 8'($random(seed));
      if (p == 0) begin
        sentQ.push_back(b);
        wr(SSP_OFS_BUF, b);
      end
      repeat (16) begin
        repeat (4) @(posedge sys_clk);
        sckPin <= ~sckPin;
      end
      repeat (4) @(posedge sys_clk);
      rd(SSP_OFS_CTRL, rd8);
      chk("overflow", p[0], rd8[SSP_CTL_OVF]);
      if (p == 0) chk("slave tx", sentQ.pop_front(), rxB);
    end
    rd(SSP_OFS_STAT, rd8);
    chk("slave full", 1'b1, rd8[SSP_STA_FULL]);
    rd(SSP_OFS_BUF, rd8);
    chk("slave rx", recvQ.pop_front(), rd8);
    wr(SSP_OFS_DIR, 8'h07);
    repeat (2) @(posedge sys_clk);
    chk("sdo override", 1'b0, sdoOe);
    give_verdict();
  end
endmodule : spi_master_slave_port_test

/* File: tb/ssp_spi_partner.sv */
`timescale 1ns/10ps
module ssp_spi_partner (
  input  wire logic       sys_clk,
  input  wire logic       pol,
  input  wire logic       load,
  input  wire logic [7:0] txByte,
  input  wire logic       sck,
  input  wire logic       sdo,
  output logic            sdi,
  output logic [7:0]      rxByte
);
  logic [7:0] txSh;
  logic       sckLast;
  assign sdi = txSh[7];
  always @(posedge sys_clk) begin
    sckLast <= sck;
    if (load) txSh <= txByte;
    else if (sck != sckLast && sck == pol) txSh <= {txSh[6:0], 1'b0};
    if (sck != sckLast && sck != pol) rxByte <= {rxByte[6:0], sdo};
  end
endmodule : ssp_spi_partner

/* File: tb/ssp_spi_port_asserts.sv */
`timescale 1ns/10ps
module ssp_spi_port_asserts
  import ssp_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic [4:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0]  avsByteEnable,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitRequest,
  input wire logic        sckOut,
  input wire logic        sckOe,
  input wire logic        sdoOe,
  input wire logic        ssInN
);
  logic [7:0] ctrlSh_reg;
  logic [7:0] dirSh_reg;
  logic [9:0] quiet_reg;
  logic       wrLane;
  logic       en;
  logic       master;
  logic       slvSel;
  assign wrLane = avsWrite && avsByteEnable[0];
  assign en     = ctrlSh_reg[SSP_CTL_EN];
  assign master = en && (ctrlSh_reg[3:0] <= SSP_MODE_TIMER_TWO);
  assign slvSel = en && ctrlSh_reg[3:0] == SSP_MODE_SLV_SS && dirSh_reg[SSP_DIR_SS];
  // shadows follow software writes only; flag bits set by hardware are not used
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlSh_reg <= SSP_CTRL_RST;
      dirSh_reg  <= SSP_DIR_RST;
      quiet_reg  <= 10'h000;
    end else begin
      if (wrLane && avsAddress == SSP_OFS_CTRL) ctrlSh_reg <= avsWriteData[7:0];
      if (wrLane && avsAddress == SSP_OFS_DIR) dirSh_reg <= avsWriteData[7:0];
      // longest byte is 17 halves of 32 cycles, so 600 quiet cycles means idle
      if (avsWrite) quiet_reg <= 10'h000;
      else if (quiet_reg != 10'h3ff) quiet_reg <= quiet_reg + 10'h001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence rdWait;
    avsWaitRequest ##1 !avsWaitRequest;
  endsequence
  chk_write_nowait: assert property (avsWrite |-> !avsWaitRequest)
    else $error("write was held off");
  chk_read_wait: assert property (avsRead && !$past(avsRead) |-> rdWait)
    else $error("read answer not in second cycle");
  chk_read_upper: assert property (avsRead && !avsWaitRequest |-> avsReadData[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_off_quiet: assert property ((!en) [*2] |-> !sdoOe && !sckOe)
    else $error("pins driven while disabled");
  chk_dir_sdo: assert property (dirSh_reg[SSP_DIR_SDO] |-> !sdoOe)
    else $error("data out driven against direction");
  chk_dir_sck: assert property (dirSh_reg[SSP_DIR_SCK] |-> !sckOe)
    else $error("clock driven against direction");
  chk_slave_noclk: assert property (en && !master && ctrlSh_reg[3:2] == 2'b01 |-> !sckOe)
    else $error("clock driven in slave mode");
  chk_master_clk: assert property ((master && !dirSh_reg[SSP_DIR_SCK]) [*2] |-> sckOe)
    else $error("master not driving clock");
  chk_select_off: assert property ((slvSel && ssInN) [*2] |-> !sdoOe)
    else $error("data out driven with select high");
  chk_idle_level: assert property (quiet_reg > 10'h258 && master && sckOe |->
    sckOut == ctrlSh_reg[SSP_CTL_POL])
    else $error("clock idle level wrong");
endmodule : ssp_spi_port_asserts
bind ssp_spi_port ssp_spi_port_asserts u_chk (.sys_clk, .reset_n, .avsAddress, .avsRead,
  .avsWrite, .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitRequest, .sckOut,
  .sckOe, .sdoOe, .ssInN);
